//--- rtl/afdr_top.sv
`timescale 1ns/1ps
`default_nettype none
module afdr_top
   import afdr_pkg::*;
#(
   parameter int LUT_DEPTH = 16 // entries per table set
)
(
   input wire logic clk, // 20 MHz clock
   input wire logic resetn, // sync reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic frame_start, // one-cycle input frame pulse
   input wire logic afd_valid, // one-cycle AFD packet found
   input wire logic [AFDR_LW-1:0] afd_line, // line of the packet
   input wire logic afd_ar, // coded frame 1 = 16:9
   input wire logic [3:0] afd_code, // active format code
   input wire logic out_ar, // output coded frame 1 = 16:9
   output logic out_afd_en, // insert AFD on output
   output logic [AFDR_LW-1:0] out_afd_line, // output insertion line
   output logic [3:0] out_afd_code, // output code
   output logic [2:0] eff_mode, // mode in effect
   output logic afd_tables, // AFD table set selected
   output logic irq // level interrupt
);
   // ------------------------------------------------------------
   // Bus and control registers
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   logic rd_err;
   logic wr_stb;
   logic rd_stb;
   logic proc_en_q;
   afdr_mode_e mode_q;
   logic [AFDR_LW-1:0] in_sw_q;
   logic [AFDR_LW-1:0] out_sw_q;
   logic [AFDR_LW-1:0] vbi_q;
   logic [3:0] lut_q [0:2*LUT_DEPTH-1];
   logic [AFDR_NEV-1:0] irq_stat_q;
   logic [AFDR_NEV-1:0] irq_mask_q;
   logic [7:0] lut_idx_q;

   afdr_apb_slave u_apb
   (
      .clk(clk),
      .resetn(resetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .prdata_in(rd_mux),
      .pready(pready),
      .pslverr(pslverr),
      .prdata(prdata),
      .rd_err(rd_err),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb)
   );

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   always_ff @(posedge clk)
   begin
      if (!resetn)
         proc_en_q <= AFDR_CTRL_RST;
      else if (wr_stb && hit(paddr, AFDR_CTRL_OFS))
         proc_en_q <= pwdata[0];
   end

   // Auto is refused and cleared while processing is off
   always_ff @(posedge clk)
   begin
      if (!resetn)
         mode_q <= AFDR_MODE_FULL_WIDTH;
      else if (wr_stb && hit(paddr, AFDR_MODE_OFS))
      begin
         if (pwdata[2:0] == AFDR_MODE_AUTO && !proc_en_q)
            mode_q <= AFDR_MODE_FULL_WIDTH;
         else if (pwdata[2:0] <= AFDR_MODE_ANAMORPHIC)
            mode_q <= afdr_mode_e'(pwdata[2:0]);
      end
      else if (!proc_en_q && mode_q == AFDR_MODE_AUTO)
         mode_q <= AFDR_MODE_FULL_WIDTH;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         in_sw_q <= AFDR_IN_SW_RST;
         out_sw_q <= AFDR_OUT_SW_RST;
      end
      else if (wr_stb && hit(paddr, AFDR_SWLINE_OFS))
      begin
         in_sw_q <= pwdata[AFDR_LW-1:0];
         out_sw_q <= pwdata[AFDR_SW_OUT_LSB +: AFDR_LW];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         vbi_q <= AFDR_VBI_RST;
      else if (wr_stb && hit(paddr, AFDR_VBI_OFS))
         vbi_q <= pwdata[AFDR_LW-1:0];
   end

   // Lookup: index = {set, input code}; set 1 for AFD table set
   always_ff @(posedge clk)
   begin
      if (!resetn)
         lut_idx_q <= 8'h00;
      else if (wr_stb && hit(paddr, AFDR_LUT_OFS))
         lut_idx_q <= pwdata[AFDR_LUT_IDX_LSB +: 8];
   end

   always_ff @(posedge clk)
   begin
      if (wr_stb && hit(paddr, AFDR_LUT_OFS) && pwdata[AFDR_LUT_WE_BIT]
          && pwdata[AFDR_LUT_IDX_LSB +: 8] < 8'(2*LUT_DEPTH))
         lut_q[pwdata[AFDR_LUT_IDX_LSB +: 5]] <= pwdata[3:0];
   end

   // ------------------------------------------------------------
   // Detection, once per frame
   // ------------------------------------------------------------
   logic seen_q;
   logic [AFDR_LW-1:0] seen_line_q;
   logic seen_ar_q;
   logic [3:0] seen_code_q;
   logic in_pres_q;
   logic [AFDR_LW-1:0] in_line_q;
   logic in_ar_q;
   logic [3:0] in_code_q;

   // Latest packet of the running frame wins
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         seen_q <= 1'b0;
         seen_line_q <= '0;
         seen_ar_q <= AFDR_AR_4X3;
         seen_code_q <= 4'h0;
      end
      else if (afd_valid)
      begin
         seen_q <= 1'b1;
         seen_line_q <= afd_line;
         seen_ar_q <= afd_ar;
         seen_code_q <= afd_code;
      end
      else if (frame_start)
         seen_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         in_pres_q <= 1'b0;
         in_line_q <= '0;
         in_ar_q <= AFDR_AR_4X3;
         in_code_q <= 4'h0;
      end
      else if (frame_start)
      begin
         in_pres_q <= seen_q & proc_en_q;
         in_line_q <= (seen_q && proc_en_q) ? seen_line_q : '0;
         in_ar_q <= (seen_q && proc_en_q) ? seen_ar_q : AFDR_AR_4X3;
         in_code_q <= (seen_q && proc_en_q) ? seen_code_q : 4'h0;
      end
      else if (!proc_en_q)
      begin
         in_pres_q <= 1'b0;
         in_line_q <= '0;
         in_ar_q <= AFDR_AR_4X3;
         in_code_q <= 4'h0;
      end
   end

   // ------------------------------------------------------------
   // Output side
   // ------------------------------------------------------------
   logic [AFDR_LW-1:0] calc_line;
   logic [3:0] lut_out;

   afdr_line_calc u_line
   (
      .in_line(in_line_q),
      .in_sw(in_sw_q),
      .out_sw(out_sw_q),
      .out_vbi_end(vbi_q),
      .out_line(calc_line)
   );

   assign lut_out = lut_q[{1'b1, in_code_q}];

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         out_afd_en <= 1'b0;
         out_afd_line <= '0;
         out_afd_code <= 4'h0;
      end
      else if (in_pres_q && proc_en_q)
      begin
         out_afd_en <= 1'b1;
         out_afd_line <= calc_line;
         out_afd_code <= lut_out;
      end
      else
      begin
         out_afd_en <= 1'b0;
         out_afd_line <= '0;
         out_afd_code <= 4'h0;
      end
   end

   // Auto only acts on AFD input, otherwise full width
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         eff_mode <= AFDR_MODE_FULL_WIDTH;
         afd_tables <= 1'b0;
      end
      else
      begin
         afd_tables <= in_pres_q & proc_en_q;
         if (mode_q == AFDR_MODE_AUTO && !(in_pres_q && proc_en_q))
            eff_mode <= AFDR_MODE_FULL_WIDTH;
         else
            eff_mode <= mode_q;
      end
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   logic [AFDR_NEV-1:0] ev;
   logic [AFDR_NEV-1:0] stat_nx;
   logic rd_stat;
   assign rd_stat = rd_stb && hit(paddr, AFDR_IRQ_STAT_OFS);
   always_comb
   begin
      ev = '0;
      ev[AFDR_EV_FOUND] = frame_start & seen_q & proc_en_q & ~in_pres_q;
      ev[AFDR_EV_LOST] = frame_start & ~(seen_q & proc_en_q) & in_pres_q;
      ev[AFDR_EV_CHANGE] = frame_start & seen_q & proc_en_q & in_pres_q & (seen_code_q != in_code_q);
   end

   // Read clears only the bits it returned; an event set in its setup cycle survives
   assign stat_nx = (rd_stat ? (irq_stat_q & ~prdata[AFDR_NEV-1:0]) : irq_stat_q) | ev;

   // New event beats the read-clear
   always_ff @(posedge clk)
   begin
      if (!resetn)
         irq_stat_q <= '0;
      else
         irq_stat_q <= stat_nx;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         irq_mask_q <= '0;
      else if (wr_stb && hit(paddr, AFDR_IRQ_MASK_OFS))
         irq_mask_q <= pwdata[AFDR_NEV-1:0];
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         irq <= 1'b0;
      else
         irq <= |(stat_nx & irq_mask_q);
   end

   // ------------------------------------------------------------
   // Read decode; status words ignore writes
   // ------------------------------------------------------------
   always_comb
   begin
      rd_mux = 32'h0;
      rd_err = 1'b0;
      if (hit(paddr, AFDR_CTRL_OFS))
         rd_mux[0] = proc_en_q;
      else if (hit(paddr, AFDR_MODE_OFS))
         rd_mux[2:0] = mode_q;
      else if (hit(paddr, AFDR_INSTAT_OFS))
      begin
         rd_mux[AFDR_ST_LINE_LSB +: AFDR_LW] = in_line_q;
         rd_mux[AFDR_ST_AR_BIT] = in_ar_q;
         rd_mux[AFDR_ST_CODE_LSB +: 4] = in_code_q;
         rd_mux[AFDR_ST_PRES_BIT] = in_pres_q;
      end
      else if (hit(paddr, AFDR_OUTSTAT_OFS))
      begin
         rd_mux[AFDR_ST_LINE_LSB +: AFDR_LW] = out_afd_line;
         rd_mux[AFDR_ST_AR_BIT] = out_afd_en & out_ar;
         rd_mux[AFDR_ST_CODE_LSB +: 4] = out_afd_code;
         rd_mux[AFDR_ST_PRES_BIT] = out_afd_en;
      end
      else if (hit(paddr, AFDR_SWLINE_OFS))
      begin
         rd_mux[AFDR_LW-1:0] = in_sw_q;
         rd_mux[AFDR_SW_OUT_LSB +: AFDR_LW] = out_sw_q;
      end
      else if (hit(paddr, AFDR_VBI_OFS))
         rd_mux[AFDR_LW-1:0] = vbi_q;
      else if (hit(paddr, AFDR_LUT_OFS))
      begin
         rd_mux[AFDR_LUT_IDX_LSB +: 8] = lut_idx_q;
         if (lut_idx_q < 8'(2*LUT_DEPTH))
            rd_mux[3:0] = lut_q[lut_idx_q[4:0]];
      end
      else if (hit(paddr, AFDR_IRQ_STAT_OFS))
         rd_mux[AFDR_NEV-1:0] = irq_stat_q;
      else if (hit(paddr, AFDR_IRQ_MASK_OFS))
         rd_mux[AFDR_NEV-1:0] = irq_mask_q;
      else
         rd_err = 1'b1;
   end
endmodule // afdr_top
`default_nettype wire

//--- common/afdr_pkg.sv
package afdr_pkg;
   // Register byte offsets
   localparam logic [7:0] AFDR_CTRL_OFS = 8'h00;
   localparam logic [7:0] AFDR_MODE_OFS = 8'h04;
   localparam logic [7:0] AFDR_INSTAT_OFS = 8'h08;
   localparam logic [7:0] AFDR_OUTSTAT_OFS = 8'h0c;
   localparam logic [7:0] AFDR_SWLINE_OFS = 8'h10;
   localparam logic [7:0] AFDR_VBI_OFS = 8'h14;
   localparam logic [7:0] AFDR_LUT_OFS = 8'h18;
   localparam logic [7:0] AFDR_IRQ_STAT_OFS = 8'h1c;
   localparam logic [7:0] AFDR_IRQ_MASK_OFS = 8'h20;
   // Field widths and positions, default line offset
   localparam int AFDR_LW = 11;
   localparam int AFDR_ST_LINE_LSB = 0;
   localparam int AFDR_ST_AR_BIT = 11;
   localparam int AFDR_ST_CODE_LSB = 12;
   localparam int AFDR_ST_PRES_BIT = 16;
   localparam int AFDR_SW_OUT_LSB = 16;
   localparam int AFDR_LUT_IDX_LSB = 8;
   localparam int AFDR_LUT_WE_BIT = 16;
   localparam logic [AFDR_LW-1:0] AFDR_DEFAULT_OFFSET = 11'h004;
   // Reset values
   localparam logic AFDR_CTRL_RST = 1'b1;
   localparam logic [AFDR_LW-1:0] AFDR_IN_SW_RST = 11'h00a;
   localparam logic [AFDR_LW-1:0] AFDR_OUT_SW_RST = 11'h007;
   localparam logic [AFDR_LW-1:0] AFDR_VBI_RST = 11'h014;
   // Interrupt event bits
   localparam int AFDR_EV_FOUND = 0;
   localparam int AFDR_EV_LOST = 1;
   localparam int AFDR_EV_CHANGE = 2;
   localparam int AFDR_NEV = 3;
   // Aspect ratio mode encoding
   typedef enum logic [2:0]
   {
      AFDR_MODE_AUTO = 3'h0,
      AFDR_MODE_FULL_WIDTH = 3'h1,
      AFDR_MODE_14X9 = 3'h2,
      AFDR_MODE_FULL_HEIGHT = 3'h3,
      AFDR_MODE_ANAMORPHIC = 3'h4
   } afdr_mode_e;
   localparam logic AFDR_AR_4X3 = 1'b0;
   localparam logic AFDR_AR_16X9 = 1'b1;
endpackage

//--- rtl/afdr_apb_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Zero-wait APB slave front end; decode and storage live in the top
module afdr_apb_slave
(
   input wire logic clk, // clock
   input wire logic resetn, // sync reset, active low
   input wire logic psel, // select
   input wire logic penable, // access phase
   input wire logic pwrite, // direction
   input wire logic [31:0] prdata_in, // read mux value
   output logic pready, // always ready
   output logic pslverr, // error flag
   output logic [31:0] prdata, // registered read data
   input wire logic rd_err, // unmapped address
   output logic wr_stb, // write strobe
   output logic rd_stb // read strobe
);
   assign pready = 1'b1;
   assign wr_stb = psel & penable & pwrite;
   assign rd_stb = psel & penable & ~pwrite;
   // Error taken in setup so it stands for the access phase only
   always_ff @(posedge clk)
   begin
      if (!resetn)
         pslverr <= 1'b0;
      else
         pslverr <= psel & ~penable & rd_err;
   end

   // Data registered in setup so access phase reads stable value
   always_ff @(posedge clk)
   begin
      if (!resetn)
         prdata <= 32'h0;
      else if (psel & ~penable & ~pwrite)
         prdata <= prdata_in;
   end
endmodule // afdr_apb_slave
`default_nettype wire

//--- rtl/afdr_line_calc.sv
`timescale 1ns/1ps
`default_nettype none
// Output line relocation, combinational
module afdr_line_calc
   import afdr_pkg::*;
(
   input wire logic [AFDR_LW-1:0] in_line, // detected input line
   input wire logic [AFDR_LW-1:0] in_sw, // input switching line
   input wire logic [AFDR_LW-1:0] out_sw, // output switching line
   input wire logic [AFDR_LW-1:0] out_vbi_end, // last output VBI line
   output logic [AFDR_LW-1:0] out_line // placed output line
);
   logic [AFDR_LW-1:0] diff;
   logic [AFDR_LW-1:0] cand;
   always_comb
   begin
      diff = AFDR_LW'(in_line - in_sw);
      cand = AFDR_LW'(out_sw + diff);
      // Line above switching line also counts as outside VBI
      if (in_line < in_sw || cand > out_vbi_end)
         out_line = AFDR_LW'(out_sw + AFDR_DEFAULT_OFFSET);
      else
         out_line = cand;
   end
endmodule // afdr_line_calc
`default_nettype wire

//--- bench/afdr_props.sv
`timescale 1ns/1ps
`default_nettype none
module afdr_props
   import afdr_pkg::*;
#(
   parameter int LUT_DEPTH = 16 // set size
)
(
   input wire logic clk, // clock
   input wire logic resetn, // reset
   input wire logic psel, // select
   input wire logic penable, // enable
   input wire logic pwrite, // write
   input wire logic [7:0] paddr, // address
   input wire logic [31:0] pwdata, // wdata
   input wire logic [31:0] prdata, // rdata
   input wire logic pslverr, // error
   input wire logic frame_start, // frame
   input wire logic out_afd_en, // out AFD
   input wire logic [AFDR_LW-1:0] out_afd_line, // out line
   input wire logic [2:0] eff_mode, // mode
   input wire logic afd_tables, // tables
   input wire logic irq // interrupt
);
   logic en_q;
   wire logic wr = psel && penable && pwrite;
   wire logic rdclr = psel && penable && !pwrite && paddr == AFDR_IRQ_STAT_OFS;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // -------------------------------
   // Shadow of the processing enable
   // -------------------------------
   always_ff @(posedge clk)
   begin
      if (!resetn)
         en_q <= AFDR_CTRL_RST;
      else if (wr && paddr == AFDR_CTRL_OFS)
         en_q <= pwdata[0];
   end
   a_err_unmapped: assert property (pslverr == (psel && penable && (paddr > 8'h20 || paddr[1:0] != 2'h0)))
      else $error("pslverr wrong");
   a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable))
      else $error("prdata moved");
   a_out_on_frame: assert property ($rose(out_afd_en) |-> $past(frame_start, 2))
      else $error("out AFD rose off frame");
   a_line_held: assert property (!$past(frame_start, 2) && !$past(wr) && !$past(wr, 2) && !$past(wr, 3)
      |-> $stable(out_afd_line))
      else $error("out line moved");
   a_irq_cause: assert property ($rose(irq) |-> $past(frame_start) || $past(wr) || $past(wr, 2))
      else $error("irq rose without event");
   a_irq_clears: assert property (rdclr && !frame_start && !$past(frame_start) |=> !irq)
      else $error("irq not cleared");
   a_off_bypass: assert property (!en_q [*2] |-> !out_afd_en && !afd_tables)
      else $error("status with processing off");
   a_off_mode: assert property (!en_q [*2] |-> eff_mode != AFDR_MODE_AUTO)
      else $error("auto with processing off");
   c_rd_irq: cover property (rdclr && irq);
   c_out_on: cover property ($rose(out_afd_en));
   c_err: cover property (pslverr);
endmodule // afdr_props
bind afdr_top afdr_props #(.LUT_DEPTH(LUT_DEPTH)) i_props
(
   .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
   .frame_start, .out_afd_en, .out_afd_line, .eff_mode, .afd_tables, .irq
);
`default_nettype wire

//--- bench/afdr_vid_model.sv
`timescale 1ns/1ps
`default_nettype none
module afdr_vid_model
(
   input wire logic clk, // clock
   output logic frame_start, // frame
   output logic afd_valid, // packet
   output logic [10:0] afd_line, // line
   output logic afd_ar, // ratio
   output logic [3:0] afd_code, // code
   output logic out_ar // out ratio
);
   initial
   begin
      frame_start = 1'b0;
      afd_valid = 1'b0;
      {afd_line, afd_ar, afd_code, out_ar} = '0;
   end
   // ----------------------------------
   // One frame, with or without packet
   // ----------------------------------
   task automatic send(input logic h, input logic [10:0] l, input logic a, input logic [3:0] c, input logic o);
      repeat (3) @(posedge clk);
      out_ar <= o;
      afd_valid <= h;
      {afd_line, afd_ar, afd_code} <= {l, a, c};
      @(posedge clk);
      afd_valid <= 1'b0;
      // Idle data lines show junk so a stale value cannot pass
      {afd_line, afd_ar, afd_code} <= ~{l, a, c};
      repeat (3) @(posedge clk);
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
endmodule // afdr_vid_model
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import afdr_pkg::*;
;
   logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, frame_start, afd_valid, afd_ar, out_ar, out_afd_en, afd_tables, irq, a, o, ia;
   logic [AFDR_LW-1:0] afd_line, out_afd_line;
   logic [3:0] afd_code, out_afd_code, c, d;
   logic [2:0] eff_mode;
   logic [32:0] exp_q[$], msk_q[$], mq;
   logic [AFDR_LW-1:0] lines[5] = '{11'h009, 11'h00a, 11'h00e, 11'h017, 11'h018};
   int miscompares = 0, check_count = 0;
   always #25 clk = ~clk;
   afdr_top i_dut
   (
      .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .frame_start, .afd_valid, .afd_line, .afd_ar, .afd_code, .out_ar, .out_afd_en,
      .out_afd_line, .out_afd_code, .eff_mode, .afd_tables, .irq
   );
   afdr_vid_model i_vid
   (
      .clk, .frame_start, .afd_valid, .afd_line, .afd_ar, .afd_code, .out_ar
   );
   // -----------------
   // Tasks and checks
   // -----------------
   task automatic report_and_stop;
      if (miscompares == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp(input logic [32:0] g, input logic [32:0] e);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic [7:0] ad, input logic w, input logic [31:0] dt);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= dt;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [32:0] e, input logic [32:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      xfer(ad, 1'b0, 32'h0);
   endtask
   function automatic logic [AFDR_LW-1:0] exp_line(input logic [AFDR_LW-1:0] l);
      logic [AFDR_LW-1:0] r;
      r = l - AFDR_IN_SW_RST + AFDR_OUT_SW_RST;
      return (l < AFDR_IN_SW_RST || r > AFDR_VBI_RST) ? AFDR_OUT_SW_RST + AFDR_DEFAULT_OFFSET : r;
   endfunction
   always @(posedge clk)
   begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      begin
         mq = msk_q.pop_front();
         cmp({pslverr, prdata} & mq, exp_q.pop_front() & mq);
      end
   end
   initial
   begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      void'($urandom(32'hc706f748));
      @(posedge clk);
      rd(AFDR_CTRL_OFS, 33'h1, 33'h1);
      rd(AFDR_SWLINE_OFS, {5'h0, AFDR_OUT_SW_RST, 5'h0, AFDR_IN_SW_RST}, '1);
      rd(AFDR_VBI_OFS, 33'(AFDR_VBI_RST), 33'h7ff);
      rd(8'h30, {1'b1, 32'h0}, '1);
      rd(AFDR_INSTAT_OFS, 33'h0, '1);
      for (int i = 0; i < 5; i++)
      begin
         c = 4'($urandom);
         d = 4'($urandom);
         a = 1'($urandom);
         o = 1'($urandom);
         xfer(AFDR_LUT_OFS, 1'b1, {15'h0, 1'b1, 3'h0, 1'b1, c, 4'h0, d});
         rd(AFDR_LUT_OFS, {20'h0, 1'b1, c, 4'h0, d}, 33'h1f0f);
         i_vid.send(1'b1, lines[i], a, c, o);
         @(negedge clk);
         cmp(out_afd_line, exp_line(lines[i]));
         cmp({out_afd_en, out_afd_code}, {1'b1, d});
         @(posedge clk);
         rd(AFDR_INSTAT_OFS, {16'h1, c, a, lines[i]}, '1);
         rd(AFDR_OUTSTAT_OFS, {16'h1, d, o, exp_line(lines[i])}, '1);
      end
      xfer(AFDR_INSTAT_OFS, 1'b1, 32'hffffffff);
      rd(AFDR_INSTAT_OFS, {16'h1, c, a, lines[4]}, '1);
      for (int m = 4; m >= 0; m--)
      begin
         xfer(AFDR_MODE_OFS, 1'b1, 32'(m));
         xfer(AFDR_MODE_OFS, 1'b1, 32'h5);
         rd(AFDR_MODE_OFS, 33'(m), 33'h7);
      end
      @(negedge clk);
      cmp({eff_mode, afd_tables}, {AFDR_MODE_AUTO, 1'b1});
      @(posedge clk);
      i_vid.send(1'b0, 11'h00e, 1'b0, 4'h4, 1'b0);
      @(negedge clk);
      cmp({eff_mode == AFDR_MODE_AUTO, afd_tables, out_afd_en}, 3'h0);
      @(posedge clk);
      rd(AFDR_INSTAT_OFS, 33'h0, '1);
      rd(AFDR_IRQ_STAT_OFS, 33'h2, 33'h2);
      i_vid.send(1'b1, 11'h00e, 1'b0, 4'h4, 1'b1);
      xfer(AFDR_CTRL_OFS, 1'b1, 32'h0);
      rd(AFDR_INSTAT_OFS, 33'h0, '1);
      rd(AFDR_OUTSTAT_OFS, 33'h0, 33'h10800);
      rd(AFDR_MODE_OFS, 33'h1, 33'h7);
      xfer(AFDR_MODE_OFS, 1'b1, 32'h0);
      rd(AFDR_MODE_OFS, 33'h1, 33'h7);
      i_vid.send(1'b1, 11'h00e, 1'b0, 4'h4, 1'b1);
      @(negedge clk);
      cmp({eff_mode, afd_tables, out_afd_en}, {AFDR_MODE_FULL_WIDTH, 2'h0});
      @(posedge clk);
      xfer(AFDR_CTRL_OFS, 1'b1, 32'h1);
      i_vid.send(1'b0, 11'h00e, 1'b0, 4'h4, 1'b0);
      rd(AFDR_IRQ_STAT_OFS, 33'h1, 33'h7);
      xfer(AFDR_IRQ_MASK_OFS, 1'b1, 32'h7);
      i_vid.send(1'b1, 11'h00e, 1'b0, 4'h4, 1'b0);
      @(negedge clk);
      ia = irq;
      @(posedge clk);
      rd(AFDR_IRQ_STAT_OFS, 33'h1, 33'h1);
      @(negedge clk);
      cmp(irq, 1'b0);
      @(posedge clk);
      xfer(AFDR_IRQ_MASK_OFS, 1'b1, 32'h0);
      i_vid.send(1'b0, 11'h00e, 1'b0, 4'h4, 1'b0);
      @(negedge clk);
      cmp({ia, irq}, 2'h2);
      @(posedge clk);
      rd(AFDR_IRQ_STAT_OFS, 33'h2, 33'h2);
      report_and_stop();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
